// ===== hdl/hraf_top.v
// Receive address filter, receive FIFO and event presentation
`timescale 1ns/1ps
`default_nettype none
`include "hraf_defs.vh"
module hraf_top (
   input wire REF_CLK,
   input wire RST,
   input wire [2:0] RECEIVE_MODE_SELECT,
   input wire [7:0] SERVICE_POINT_ID_ONE,
   input wire [7:0] SERVICE_POINT_ID_TWO,
   input wire [7:0] TERMINAL_ID_ONE,
   input wire [7:0] TERMINAL_ID_TWO,
   input wire [1:0] RECEIVE_THRESHOLD_SELECT,
   input wire BLOCK_ACKNOWLEDGE_CMD,
   input wire RECEIVER_RESET_CMD,
   input wire RX_FRAME_START,
   input wire RX_BYTE_VALID,
   input wire [7:0] RX_BYTE,
   input wire RX_FRAME_END,
   input wire RX_CRC_OK,
   input wire RX_ABORT,
   input wire FIFO_READ,
   output reg [7:0] FIFO_READ_DATA,
   output wire RECEIVE_POOL_FULL_EVENT,
   output wire MESSAGE_END_EVENT,
   output wire FRAME_OVERFLOW_EVENT,
   output wire [7:0] BYTE_COUNT_LOW,
   output wire [3:0] BYTE_COUNT_HIGH,
   output wire COUNT_OVERFLOW_BIT
);
   // Block size in bytes for a threshold code
   function [6:0] thr_bytes;
      input [1:0] sel;
      begin
         case (sel)
            2'h0: thr_bytes = 7'h2_0;
            2'h1: thr_bytes = 7'h1_0;
            2'h2: thr_bytes = 7'h0_8;
            default: thr_bytes = 7'h0_4;
         endcase
      end
   endfunction

   // Event entry packing
   function [`HRAF_QENT_W-1:0] pack_evt;
      input [1:0] kind;
      input [6:0] len;
      input [11:0] cnt;
      input ovf;
      begin
         pack_evt = {kind, len, cnt, ovf};
      end
   endfunction

   reg [7:0] mem_r [0:63];
   reg [6:0] wr_ptr_r;
   reg [6:0] rel_ptr_r;
   reg [6:0] rd_off_r;
   reg [1:0] thr_sel_r;
   reg in_frame_r;
   reg discard_r;
   reg [1:0] idx_r;
   reg acc_r;
   reg [1:0] sa_r;
   reg ta_r;
   reg cr_r;
   reg rdo_r;
   reg [6:0] blk_cnt_r;
   reg blk_pend_r;
   reg [11:0] cnt_r;
   reg ovf_r;

   reg take;
   reg acc_nxt;
   reg push;
   reg [`HRAF_QENT_W-1:0] push_data;
   reg wr_en;
   reg [7:0] wr_data;

   wire sap_hit;
   wire [1:0] sap_code;
   wire tei_hit;
   wire cr_bit;
   wire [`HRAF_QENT_W-1:0] head;
   wire head_valid;
   wire q_full;

   hraf_addr_match u_match (
      .addr_byte(RX_BYTE),
      .sap_one(SERVICE_POINT_ID_ONE),
      .sap_two(SERVICE_POINT_ID_TWO),
      .tei_one(TERMINAL_ID_ONE),
      .tei_two(TERMINAL_ID_TWO),
      .sap_hit(sap_hit),
      .sap_code(sap_code),
      .tei_hit(tei_hit),
      .cr_bit(cr_bit)
   );

   wire [1:0] head_kind = head[21:20];
   wire [6:0] head_len = head[19:13];
   // An overflow entry owns no FIFO space, so its acknowledge releases nothing
   wire ack_data = BLOCK_ACKNOWLEDGE_CMD && head_valid && (head_kind != `HRAF_EVT_RFO);
   wire ack_end = ack_data && (head_kind == `HRAF_EVT_RME);

   hraf_evt_queue u_queue (
      .clk(REF_CLK),
      .rst(RST),
      .clr(RECEIVER_RESET_CMD),
      .push(push),
      .push_data(push_data),
      .pop(BLOCK_ACKNOWLEDGE_CMD),
      .head_data(head),
      .head_valid(head_valid),
      .full(q_full)
   );

   // Head event presented with its status
   assign RECEIVE_POOL_FULL_EVENT = head_valid && (head_kind == `HRAF_EVT_RPF);
   assign MESSAGE_END_EVENT = head_valid && (head_kind == `HRAF_EVT_RME);
   assign FRAME_OVERFLOW_EVENT = head_valid && (head_kind == `HRAF_EVT_RFO);

   // Count shown as low byte and high nibble of the 12-bit byte count
   assign BYTE_COUNT_LOW = head_valid ? head[8:1] : 8'h0_0;
   assign BYTE_COUNT_HIGH = head_valid ? head[12:9] : 4'h0;
   assign COUNT_OVERFLOW_BIT = head_valid && head[0];

   // One byte is kept back so that an accepted frame can always be closed
   wire [6:0] used = wr_ptr_r - rel_ptr_r;
   wire room_data = (used < (`HRAF_FIFO_DEPTH - 7'h0_1));
   wire room_stat = (used < `HRAF_FIFO_DEPTH);
   wire [6:0] thr = thr_bytes(thr_sel_r);
   // Extended mode has no framing, so start and end pulses are ignored
   wire ext_mode = (RECEIVE_MODE_SELECT == `HRAF_MODE_EXT);
   wire byte_in = RX_BYTE_VALID && ((in_frame_r && !discard_r) || ext_mode);
   wire [11:0] cnt_inc = cnt_r + 12'h0_01;
   wire cnt_wrap = (cnt_r == 12'hF_FF);

   // Storage decision per received byte
   always @* begin
      take = 1'b0;
      acc_nxt = acc_r;

      case (RECEIVE_MODE_SELECT)
         `HRAF_MODE_TR0: take = 1'b1;
         `HRAF_MODE_EXT: take = 1'b1;
         `HRAF_MODE_TR1: begin
            if (idx_r == 2'h0)
               acc_nxt = sap_hit;
            else
               take = acc_r;
         end
         `HRAF_MODE_TR2: begin
            if (idx_r == 2'h1)
               acc_nxt = tei_hit;
            else if (idx_r == 2'h2)
               take = acc_r;
         end
         `HRAF_MODE_NA1: begin
            if (idx_r == 2'h0)
               acc_nxt = sap_hit;
            else
               take = acc_r;
         end
         `HRAF_MODE_NA2: begin
            if (idx_r == 2'h0)
               acc_nxt = sap_hit;
            else if (idx_r == 2'h1)
               acc_nxt = acc_r && tei_hit;
            else
               take = acc_r;
         end
         default: take = 1'b0;
      endcase
   end

   // Event and FIFO write generation
   always @* begin
      push = 1'b0;
      push_data = pack_evt(`HRAF_EVT_NONE, 7'h0_0, 12'h0_00, 1'b0);
      wr_en = 1'b0;
      wr_data = RX_BYTE;

      if (RX_FRAME_START && !ext_mode && !in_frame_r) begin
         // No room for a new frame
         if (!room_stat) begin
            push = 1'b1;
            push_data = pack_evt(`HRAF_EVT_RFO, 7'h0_0, 12'h0_00, 1'b0);
         end
      end else if (RX_FRAME_END && in_frame_r && !discard_r && !ext_mode) begin
         if (acc_r && room_stat) begin
            wr_en = 1'b1;
            wr_data = {!RX_ABORT && RX_CRC_OK, rdo_r, RX_CRC_OK, RX_ABORT, sa_r, cr_r, ta_r};
            push = 1'b1;
            push_data = pack_evt(`HRAF_EVT_RME, blk_cnt_r + 7'h0_1, cnt_inc, ovf_r || cnt_wrap);
         end
      end else if (byte_in && take && room_data) begin
         wr_en = 1'b1;
         // Block reported once message outgrows it
         if (blk_pend_r) begin
            push = 1'b1;
            push_data = pack_evt(`HRAF_EVT_RPF, thr, cnt_r, ovf_r);
         end
      end
   end

   // Receive side state
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         wr_ptr_r <= 7'h0_0;
         in_frame_r <= 1'b0;
         discard_r <= 1'b0;
         idx_r <= 2'h0;
         acc_r <= 1'b0;
         sa_r <= `HRAF_SA_NONE;
         ta_r <= 1'b0;
         cr_r <= 1'b0;
         rdo_r <= 1'b0;
         blk_cnt_r <= 7'h0_0;
         blk_pend_r <= 1'b0;
         cnt_r <= 12'h0_00;
         ovf_r <= 1'b0;
      end else if (RECEIVER_RESET_CMD) begin
         wr_ptr_r <= 7'h0_0;
         in_frame_r <= 1'b0;
         discard_r <= 1'b0;
         idx_r <= 2'h0;
         acc_r <= 1'b0;
         rdo_r <= 1'b0;
         blk_cnt_r <= 7'h0_0;
         blk_pend_r <= 1'b0;
         cnt_r <= 12'h0_00;
         ovf_r <= 1'b0;
      end else begin
         if (wr_en)
            wr_ptr_r <= wr_ptr_r + 7'h0_1;

         if (RX_FRAME_START && !ext_mode && !in_frame_r) begin
            in_frame_r <= 1'b1;
            discard_r <= !room_stat;
            idx_r <= 2'h0;
            acc_r <= (RECEIVE_MODE_SELECT == `HRAF_MODE_TR0);
            sa_r <= `HRAF_SA_NONE;
            ta_r <= 1'b0;
            cr_r <= 1'b0;
            rdo_r <= 1'b0;
            blk_cnt_r <= 7'h0_0;
            blk_pend_r <= 1'b0;
            cnt_r <= 12'h0_00;
            ovf_r <= 1'b0;
         end else if (RX_FRAME_END && in_frame_r) begin
            in_frame_r <= 1'b0;
            discard_r <= 1'b0;
            blk_pend_r <= 1'b0;
            if (wr_en) begin
               cnt_r <= cnt_inc;
               ovf_r <= ovf_r || cnt_wrap;
            end
         end else if (byte_in) begin
            acc_r <= acc_nxt;
            if (idx_r != 2'h2)
               idx_r <= idx_r + 2'h1;
            if (idx_r == 2'h0) begin
               sa_r <= sap_code;
               cr_r <= cr_bit;
            end
            if (idx_r == 2'h1)
               ta_r <= tei_hit;
            if (take && room_data) begin
               cnt_r <= cnt_inc;
               ovf_r <= ovf_r || cnt_wrap;
               // Pool-full waits for one byte past a full block
               // Block boundary at threshold
               if (blk_pend_r)
                  blk_cnt_r <= 7'h0_1;
               else
                  blk_cnt_r <= blk_cnt_r + 7'h0_1;
               blk_pend_r <= blk_pend_r ? (7'h0_1 == thr) : (blk_cnt_r + 7'h0_1 == thr);
            end else if (take) begin
               rdo_r <= 1'b1;
            end
         end

         // A frame already in progress keeps its own count
         // Acknowledged message end clears the counter
         if (ack_end && !in_frame_r && !RX_FRAME_START) begin
            cnt_r <= 12'h0_00;
            ovf_r <= 1'b0;
         end
      end
   end

   always @(posedge REF_CLK) begin
      if (wr_en && !RECEIVER_RESET_CMD)
         mem_r[wr_ptr_r[5:0]] <= wr_data;
   end

   // Host side release, read and threshold
   always @(posedge REF_CLK or posedge RST) begin
      if (RST) begin
         rel_ptr_r <= 7'h0_0;
         rd_off_r <= 7'h0_0;
         thr_sel_r <= `HRAF_THR_RESET;
         FIFO_READ_DATA <= 8'h0_0;
      end else begin
         if (BLOCK_ACKNOWLEDGE_CMD || RECEIVER_RESET_CMD)
            thr_sel_r <= RECEIVE_THRESHOLD_SELECT;

         if (RECEIVER_RESET_CMD) begin
            rel_ptr_r <= 7'h0_0;
            rd_off_r <= 7'h0_0;
         end else if (BLOCK_ACKNOWLEDGE_CMD) begin
            if (ack_data)
               rel_ptr_r <= rel_ptr_r + head_len;
            rd_off_r <= 7'h0_0;
         end else if (FIFO_READ) begin
            FIFO_READ_DATA <= mem_r[rel_ptr_r[5:0] + rd_off_r[5:0]];
            if (head_valid && (rd_off_r + 7'h0_1 < head_len))
               rd_off_r <= rd_off_r + 7'h0_1;
            else
               rd_off_r <= 7'h0_0;
         end
      end
   end
endmodule // hraf_top
`default_nettype wire

// ===== hdl/hraf_defs.vh
// Constants for the HDLC receive address filter and FIFO block
// What this block does
// - Two programmable ids each, plus group values
// - Command/response bit excluded from address compare
// - Mode 010 one-byte, 011 two-byte recognition
// - Matching frames stored without address bytes
// - Mode 110 stores every frame whole
// - Mode 111 compares first byte, service point
// - Mode 101 compares second byte, terminal id
// - Mode 100 passes data fully transparent
// - 64-byte cyclic FIFO, threshold 32/16/8/4
// - Pool-full when block ready, message longer
// - Message-end when an accepted message completes
// - Frame-overflow and discard when FIFO occupied
// - Acknowledge releases block, ends frame count
// - Receiver reset empties FIFO; host after mode
// - 12-bit byte counter with overflow bit
// - Low counter bits give last block bytes
// - Threshold loads only on acknowledge or reset
// - Many frames held; status byte appended each
// - Events queued with status, presented in turn
// - Lost bytes set data-overflow in status byte
// - Reads wrap in block; ack discards unread
// - Read without event harmless, data undefined
// - Status byte reports crc, validity, matches
`ifndef HRAF_DEFS_VH
`define HRAF_DEFS_VH
`define HRAF_MODE_NA1 3'h2
`define HRAF_MODE_NA2 3'h3
`define HRAF_MODE_EXT 3'h4
`define HRAF_MODE_TR2 3'h5
`define HRAF_MODE_TR0 3'h6
`define HRAF_MODE_TR1 3'h7
`define HRAF_GROUP_SAP 6'h3F
`define HRAF_GROUP_TEI 7'h7F
`define HRAF_FIFO_DEPTH 7'h40
`define HRAF_THR_RESET 2'h0
`define HRAF_EVT_NONE 2'h0
`define HRAF_EVT_RPF 2'h1
`define HRAF_EVT_RME 2'h2
`define HRAF_EVT_RFO 2'h3
`define HRAF_ST_VFR 7
`define HRAF_ST_RDO 6
`define HRAF_ST_CRC 5
`define HRAF_ST_RAB 4
`define HRAF_ST_SA_HI 3
`define HRAF_ST_SA_LO 2
`define HRAF_ST_CR 1
`define HRAF_ST_TA 0
`define HRAF_SA_ONE 2'h0
`define HRAF_SA_TWO 2'h1
`define HRAF_SA_GROUP 2'h2
`define HRAF_SA_NONE 2'h3
`define HRAF_QPTR_W 5
`define HRAF_QENT_W 22
`endif

// ===== hdl/hraf_addr_match.v
// Address byte comparison against programmed and group identifiers
`timescale 1ns/1ps
`default_nettype none
`include "hraf_defs.vh"
module hraf_addr_match (
   input wire [7:0] addr_byte,
   input wire [7:0] sap_one,
   input wire [7:0] sap_two,
   input wire [7:0] tei_one,
   input wire [7:0] tei_two,
   output wire sap_hit,
   output reg [1:0] sap_code,
   output wire tei_hit,
   output wire cr_bit
);
   wire [5:0] sap_field = addr_byte[7:2];
   wire [6:0] tei_field = addr_byte[7:1];
   assign cr_bit = addr_byte[1];
   always @* begin
      if (sap_field == sap_one[7:2])
         sap_code = `HRAF_SA_ONE;
      else if (sap_field == sap_two[7:2])
         sap_code = `HRAF_SA_TWO;
      else if (sap_field == `HRAF_GROUP_SAP)
         sap_code = `HRAF_SA_GROUP;
      else
         sap_code = `HRAF_SA_NONE;
   end
   assign sap_hit = (sap_code != `HRAF_SA_NONE);
   assign tei_hit = (tei_field == tei_one[7:1]) || (tei_field == tei_two[7:1]) ||
                    (tei_field == `HRAF_GROUP_TEI);
endmodule // hraf_addr_match
`default_nettype wire

// ===== hdl/hraf_evt_queue.v
// Wait line of pending receive events with their status
`timescale 1ns/1ps
`default_nettype none
`include "hraf_defs.vh"
module hraf_evt_queue (
   input wire clk,
   input wire rst,
   input wire clr,
   input wire push,
   input wire [`HRAF_QENT_W-1:0] push_data,
   input wire pop,
   output wire [`HRAF_QENT_W-1:0] head_data,
   output wire head_valid,
   output wire full
);
   reg [`HRAF_QENT_W-1:0] ent_r [0:15];
   reg [`HRAF_QPTR_W-1:0] wp_r;
   reg [`HRAF_QPTR_W-1:0] rp_r;
   wire [`HRAF_QPTR_W-1:0] lvl = wp_r - rp_r;
   assign head_valid = (lvl != 5'h0_0);
   assign full = (lvl == 5'h1_0);
   assign head_data = ent_r[rp_r[3:0]];
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         wp_r <= 5'h0_0;
         rp_r <= 5'h0_0;
      end else if (clr) begin
         wp_r <= 5'h0_0;
         rp_r <= 5'h0_0;
      end else begin
         if (push && !full)
            wp_r <= wp_r + 5'h0_1;
         if (pop && head_valid)
            rp_r <= rp_r + 5'h0_1;
      end
   end
   always @(posedge clk) begin
      if (push && !full && !clr)
         ent_r[wp_r[3:0]] <= push_data;
   end
endmodule // hraf_evt_queue
`default_nettype wire

// ===== sim/hraf_host_model.sv
// Host model: receiver commands and receive FIFO reads
`timescale 1ns/1ps
`default_nettype none
module hraf_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] read_data,
   output logic fifo_read,
   output logic block_ack,
   output logic rx_reset,
   output logic [2:0] mode_sel,
   output logic [1:0] thr_sel
);
   initial begin
      fifo_read = 1'b0;
      block_ack = 1'b0;
      rx_reset = 1'b0;
      mode_sel = 3'h6;
      thr_sel = 2'h0;
   end
   task reset_rx(input logic [2:0] m, input logic [1:0] t);
      @(posedge ref_clk) mode_sel <= m;
      thr_sel <= t;
      @(posedge ref_clk) rx_reset <= 1'b1;
      @(posedge ref_clk) rx_reset <= 1'b0;
   endtask
   task ack;
      @(posedge ref_clk) block_ack <= 1'b1;
      @(posedge ref_clk) block_ack <= 1'b0;
   endtask
   // Data is registered one cycle after the read pulse
   task read(output logic [7:0] d);
      @(posedge ref_clk) fifo_read <= 1'b1;
      @(posedge ref_clk) fifo_read <= 1'b0;
      #1 d = read_data;
   endtask
endmodule // hraf_host_model
`default_nettype wire

// ===== sim/hraf_monitor.sv
// Port checker for the receive filter and FIFO
`timescale 1ns/1ps
`default_nettype none
module hraf_monitor (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic BLOCK_ACKNOWLEDGE_CMD,
   input wire logic RECEIVER_RESET_CMD,
   input wire logic RX_FRAME_START,
   input wire logic RX_BYTE_VALID,
   input wire logic RX_FRAME_END,
   input wire logic FIFO_READ,
   input wire logic [7:0] FIFO_READ_DATA,
   input wire logic RECEIVE_POOL_FULL_EVENT,
   input wire logic MESSAGE_END_EVENT,
   input wire logic FRAME_OVERFLOW_EVENT,
   input wire logic [7:0] BYTE_COUNT_LOW,
   input wire logic [3:0] BYTE_COUNT_HIGH
);
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RST);
   wire logic any_evt = RECEIVE_POOL_FULL_EVENT | MESSAGE_END_EVENT | FRAME_OVERFLOW_EVENT;
   wire logic [11:0] cnt = {BYTE_COUNT_HIGH, BYTE_COUNT_LOW};
   wire logic ack = BLOCK_ACKNOWLEDGE_CMD;
   property p_one_evt;
      $onehot0({RECEIVE_POOL_FULL_EVENT, MESSAGE_END_EVENT, FRAME_OVERFLOW_EVENT});
   endproperty
   a_one_evt: assert property (p_one_evt) else $error("two events at once");
   property p_zero_cnt;
      !any_evt |-> cnt == 12'h000;
   endproperty
   a_zero_cnt: assert property (p_zero_cnt) else $error("count without event");
   property p_receiver_reset_cmd;
      RECEIVER_RESET_CMD |=> !any_evt;
   endproperty
   a_receiver_reset_cmd: assert property (p_receiver_reset_cmd) else $error("event after receiver reset");
   property p_rme_rise;
      $rose(MESSAGE_END_EVENT) |-> $past(RX_FRAME_END) || $past(ack);
   endproperty
   a_rme_rise: assert property (p_rme_rise) else $error("message end without cause");
   property p_rpf_rise;
      $rose(RECEIVE_POOL_FULL_EVENT) |-> $past(RX_BYTE_VALID) || $past(ack);
   endproperty
   a_rpf_rise: assert property (p_rpf_rise) else $error("pool full without cause");
   property p_rfo_rise;
      $rose(FRAME_OVERFLOW_EVENT) |-> $past(RX_FRAME_START) || $past(ack);
   endproperty
   a_rfo_rise: assert property (p_rfo_rise) else $error("overflow without cause");
   property p_fall;
      $fell(any_evt) |-> $past(ack) || $past(RECEIVER_RESET_CMD);
   endproperty
   a_fall: assert property (p_fall) else $error("event dropped unacknowledged");
   property p_cnt_hold;
      any_evt && !ack && !RECEIVER_RESET_CMD |=> $stable(cnt);
   endproperty
   a_cnt_hold: assert property (p_cnt_hold) else $error("count moved while pending");
   property p_rd_hold;
      !FIFO_READ && !RECEIVER_RESET_CMD |=> $stable(FIFO_READ_DATA);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
   property p_rme_cnt;
      MESSAGE_END_EVENT |-> cnt != 12'h000;
   endproperty
   a_rme_cnt: assert property (p_rme_cnt) else $error("message end with zero count");
   c_rpf: cover property ($rose(RECEIVE_POOL_FULL_EVENT));
   c_rme: cover property ($rose(MESSAGE_END_EVENT));
   c_rfo: cover property ($rose(FRAME_OVERFLOW_EVENT));
endmodule // hraf_monitor
bind hraf_top hraf_monitor u_mon (.REF_CLK(REF_CLK), .RST(RST), .BLOCK_ACKNOWLEDGE_CMD(BLOCK_ACKNOWLEDGE_CMD),
   .RECEIVER_RESET_CMD(RECEIVER_RESET_CMD), .RX_FRAME_START(RX_FRAME_START), .RX_BYTE_VALID(RX_BYTE_VALID),
   .RX_FRAME_END(RX_FRAME_END), .FIFO_READ(FIFO_READ), .FIFO_READ_DATA(FIFO_READ_DATA),
   .RECEIVE_POOL_FULL_EVENT(RECEIVE_POOL_FULL_EVENT), .MESSAGE_END_EVENT(MESSAGE_END_EVENT),
   .FRAME_OVERFLOW_EVENT(FRAME_OVERFLOW_EVENT), .BYTE_COUNT_LOW(BYTE_COUNT_LOW), .BYTE_COUNT_HIGH(BYTE_COUNT_HIGH));
`default_nettype wire

// ===== sim/hraf_top_tb.sv
// Testbench for the receive filter and FIFO
`timescale 1ns/1ps
`default_nettype none
module hraf_top_tb;
   logic ref_clk, rst, rx_start, rx_valid, rx_end, crc_ok, abort_in;
   logic [7:0] rx_byte, d;
   wire logic f_rd, b_ack, r_rst, receive_pool_full_event, message_end_event, frame_overflow_event, c_ov;
   wire logic [2:0] mode;
   wire logic [1:0] thr;
   wire logic [7:0] rd_data, c_lo;
   wire logic [3:0] c_hi;
   integer mismatches, samples_checked, i;
   logic [7:0] fb[$];
   // Mode, first byte, second byte, hit
   logic [23:0] tbl [0:10] = '{24'h24_2111, 24'h24_5110, 24'h2F_D111, 24'h28_3111, 24'h34_2231, 24'h34_2270,
      24'h3F_EFF1, 24'h74_1001, 24'h7C_0000, 24'h50_0451, 24'h50_0290};
   hraf_top DUT (.REF_CLK(ref_clk), .RST(rst), .RECEIVE_MODE_SELECT(mode), .SERVICE_POINT_ID_ONE(8'h40),
      .SERVICE_POINT_ID_TWO(8'h80), .TERMINAL_ID_ONE(8'h22), .TERMINAL_ID_TWO(8'h44),
      .RECEIVE_THRESHOLD_SELECT(thr), .BLOCK_ACKNOWLEDGE_CMD(b_ack), .RECEIVER_RESET_CMD(r_rst),
      .RX_FRAME_START(rx_start), .RX_BYTE_VALID(rx_valid), .RX_BYTE(rx_byte), .RX_FRAME_END(rx_end),
      .RX_CRC_OK(crc_ok), .RX_ABORT(abort_in), .FIFO_READ(f_rd), .FIFO_READ_DATA(rd_data),
      .RECEIVE_POOL_FULL_EVENT(receive_pool_full_event), .MESSAGE_END_EVENT(message_end_event), .FRAME_OVERFLOW_EVENT(frame_overflow_event),
      .BYTE_COUNT_LOW(c_lo), .BYTE_COUNT_HIGH(c_hi), .COUNT_OVERFLOW_BIT(c_ov));
   hraf_host_model u_host (.ref_clk(ref_clk), .read_data(rd_data), .fifo_read(f_rd), .block_ack(b_ack),
      .rx_reset(r_rst), .mode_sel(mode), .thr_sel(thr));
   task chk(input string nm, input logic [11:0] e, input logic [11:0] g);
      samples_checked++;
      if (g !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", nm, e, g);
      end
   endtask
   task send;
      integer k;
      @(posedge ref_clk) rx_start <= 1'b1;
      for (k = 0; k < fb.size(); k++) begin
         @(posedge ref_clk) rx_start <= 1'b0;
         rx_valid <= 1'b1;
         rx_byte <= fb[k];
      end
      @(posedge ref_clk) rx_start <= 1'b0;
      rx_valid <= 1'b0;
      rx_end <= 1'b1;
      @(posedge ref_clk) rx_end <= 1'b0;
   endtask
   task fill(input integer n, input logic [7:0] b);
      fb.delete();
      for (i = 0; i < n; i++) fb.push_back(b + i[7:0]);
      send;
   endtask
   // Bounded wait, then compare the event kind
   task wait_evt(input logic [2:0] e);
      integer k;
      for (k = 0; k < 8 && (receive_pool_full_event | message_end_event | frame_overflow_event) !== 1'b1; k++) @(posedge ref_clk);
      #1 chk("event", {9'h0, e}, {9'h0, frame_overflow_event, message_end_event, receive_pool_full_event});
   endtask
   task rd(input string nm, input logic [7:0] e);
      u_host.read(d);
      chk(nm, {4'h0, e}, {4'h0, d});
   endtask
   task wrap_up;
      $display("checks %0d mismatches %0d", samples_checked, mismatches);
      if (mismatches == 0 && samples_checked > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      ref_clk = 1'b0;
      forever #12.5 ref_clk = ~ref_clk;
   end
   // Whole run needs a few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      mismatches++;
      wrap_up;
   end
   initial begin
      rst = 1'b1;
      {rx_start, rx_valid, rx_end, abort_in} = 4'h0;
      crc_ok = 1'b1;
      rx_byte = 8'h00;
      mismatches = 0;
      samples_checked = 0;
      repeat (3) @(posedge ref_clk);
      rst <= 1'b0;
      u_host.reset_rx(3'h6, 2'h0);
      fill(5, 8'h01);
      wait_evt(3'b010);
      chk("count", 12'h006, {c_hi, c_lo});
      chk("count overflow", 12'h000, {11'h0, c_ov});
      for (i = 0; i < 5; i++) rd("data", fb[i]);
      u_host.read(d);
      chk("status", 12'h00A, {8'h0, d[7:4]});
      rd("wrap", 8'h01);
      u_host.ack;
      wait_evt(3'b000);
      $display("Test transparent done");
      u_host.reset_rx(3'h6, 2'h3);
      fill(4, 8'h10);
      wait_evt(3'b010);
      u_host.ack;
      fill(10, 8'h20);
      wait_evt(3'b001);
      rd("block", 8'h20);
      u_host.ack;
      wait_evt(3'b001);
      rd("block", 8'h24);
      u_host.ack;
      wait_evt(3'b010);
      chk("last", 12'h003, {10'h0, c_lo[1:0]});
      rd("block", 8'h28);
      u_host.ack;
      $display("Test threshold done");
      for (i = 0; i < 11; i++) begin
         u_host.reset_rx(tbl[i][22:20], 2'h0);
         fb = '{tbl[i][19:12], tbl[i][11:4], 8'hD5};
         send;
         wait_evt({1'b0, tbl[i][0], 1'b0});
         if (tbl[i][0] && !tbl[i][22]) begin
            chk("count", 12'h005 - {9'h0, tbl[i][22:20]}, {c_hi, c_lo});
            rd("payload", tbl[i][20] ? 8'hD5 : tbl[i][11:4]);
         end
         if (tbl[i][0]) u_host.ack;
      end
      u_host.reset_rx(3'h4, 2'h3);
      fill(5, 8'h30);
      wait_evt(3'b001);
      chk("ext count", 12'h004, {c_hi, c_lo});
      rd("ext", 8'h30);
      $display("Test address done");
      u_host.reset_rx(3'h6, 2'h0);
      fill(64, 8'h40);
      fill(2, 8'h77);
      wait_evt(3'b001);
      u_host.ack;
      wait_evt(3'b010);
      chk("last", 12'h000, {7'h0, c_lo[4:0]});
      for (i = 0; i < 32; i++) u_host.read(d);
      chk("data overflow", 12'h001, {11'h0, d[6]});
      u_host.ack;
      wait_evt(3'b100);
      u_host.ack;
      wait_evt(3'b000);
      $display("Test overflow done");
      fill(3, 8'h50);
      u_host.reset_rx(3'h6, 2'h0);
      wait_evt(3'b000);
      @(posedge ref_clk) u_host.thr_sel <= 2'h3;
      fill(5, 8'h60);
      wait_evt(3'b010);
      u_host.ack;
      fill(5, 8'h60);
      wait_evt(3'b001);
      $display("Test reset done");
      wrap_up;
   end
endmodule // hraf_top_tb
`default_nettype wire
